// ===== hdl/eps_pkg.sv
// eps_pkg: constants for the per-port ethernet statistics counter bank.
// assumes a single 100 MHz clock domain shared with the mac and fifo event sources.

package eps_pkg;

	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 2;
	localparam int CNT_W = 32;
	localparam int LEN_W = 14;
	localparam int CMP_W = 15;
	localparam int NUM_CNT = 64;
	localparam int IDX_W = 6;
	localparam int COLL_W = 4;

	// ****************************************************************
	// register map (byte addresses, one 32-bit word each)
	// ****************************************************************
	localparam logic [15:0] ADDR_MAX_LEN = 16'h0000;
	// counters sit at page CNT_PAGE + port, word index = counter index
	localparam logic [7:0] CNT_PAGE = 8'h10;
	localparam logic [3:0] BE_FULL = 4'hf;

	// ****************************************************************
	// frame length limits
	// ****************************************************************
	localparam logic [CMP_W-1:0] LEN_MIN = 15'h0040;
	localparam logic [CMP_W-1:0] LEN_B127 = 15'h007f;
	localparam logic [CMP_W-1:0] LEN_B255 = 15'h00ff;
	localparam logic [CMP_W-1:0] LEN_B511 = 15'h01ff;
	localparam logic [CMP_W-1:0] LEN_B1023 = 15'h03ff;
	localparam logic [CMP_W-1:0] LEN_STD_MAX = 15'h05ee;
	localparam logic [CMP_W-1:0] VLAN_EXTRA = 15'h0004;
	localparam logic [LEN_W-1:0] MAX_LEN_RST = LEN_STD_MAX[LEN_W-1:0];
	localparam logic [COLL_W-1:0] BACKOFF_MIN = 4'h2;

	typedef enum logic [1:0] {
		EPS_DEST_UNICAST = 2'b00,
		EPS_DEST_MULTICAST = 2'b01,
		EPS_DEST_BROADCAST = 2'b10
	} eps_dest_t;

	// ****************************************************************
	// counter indices
	// ****************************************************************
	localparam logic [IDX_W-1:0] IX_RX_ALL_BYTES = 6'h00, IX_INGRESS_OVERFLOW_DROP_COUNT = 6'h01,
		IX_RX_SYMBOL_ERRORS = 6'h02, IX_RX_PAUSE_FRAMES = 6'h03,
		IX_RX_UNKNOWN_CONTROL_OPCODE = 6'h04, IX_RX_GOOD_BYTES = 6'h05, IX_RX_BAD_BYTES = 6'h06,
		IX_RX_GOOD_UNICAST = 6'h07, IX_RX_GOOD_MULTICAST = 6'h08, IX_RX_GOOD_BROADCAST = 6'h09,
		IX_RX_FCS_ONLY = 6'h0a, IX_RX_ALIGN_ERRORS = 6'h0b, IX_RX_SHORT_GOOD_FCS = 6'h0c,
		IX_RX_SHORT_BAD_FCS = 6'h0d, IX_RX_LENGTH_MISMATCH = 6'h0e, IX_RX_LENGTH_ILLEGAL = 6'h0f,
		IX_RX_LONG_GOOD_FCS = 6'h10, IX_RX_LONG_BAD_FCS = 6'h11, IX_RX_BIN_BASE = 6'h12,
		IX_RX_BIN_ABOVE_STANDARD = 6'h18, IX_RX_GAP_SHRINK_EVENTS = 6'h19;
	localparam logic [IDX_W-1:0] IX_TX_ALL_BYTES = 6'h1a, IX_EGRESS_OVERFLOW_DROP_COUNT = 6'h1b,
		IX_EGRESS_AGING_DROP_COUNT = 6'h1c, IX_TX_PAUSE_FRAMES = 6'h1d, IX_TX_GOOD_BYTES = 6'h1e,
		IX_TX_UNICAST = 6'h1f, IX_TX_MULTICAST = 6'h20, IX_TX_BROADCAST = 6'h21,
		IX_TX_OK_AFTER_MANY_COLLISIONS = 6'h22, IX_TX_LATE_COLLISION_EVENTS = 6'h23,
		IX_TX_EXCESS_COLLISION_LOSSES = 6'h24, IX_TX_FIRST_ATTEMPT_DEFERRED = 6'h25,
		IX_TX_EXCESS_DEFERRAL_FRAMES = 6'h26, IX_TX_CARRIER_SENSE_ERRORS = 6'h27,
		IX_TX_BIN_BASE = 6'h28, IX_TX_BIN_ABOVE_STANDARD = 6'h2e,
		IX_TX_OK_AFTER_ONE_COLLISION = 6'h2f, IX_TX_UNDERRUN_DROPS = 6'h30,
		IX_TX_OK_AFTER_N_BACKOFFS = 6'h31, IX_TX_BACKOFF_LAST = 6'h3e;

endpackage : eps_pkg

// ===== hdl/eps_port_stats.sv
// eps_port_stats: per-port statistics counter bank with an avalon-mm slave.
// assumes all event strobes are one-cycle pulses synchronous to clk_in, one frame
// event per direction per cycle, each carrying its own port number.
`timescale 1ns/10ps

module eps_port_stats (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// avalon-mm slave
	input wire logic [15:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// receive mac frame events
	input wire logic rx_frame_done_in,
	input wire logic [eps_pkg::PORT_W-1:0] rx_port_in,
	input wire logic [eps_pkg::LEN_W-1:0] rx_length_in,
	input wire logic [1:0] rx_dest_class_in,
	input wire logic rx_vlan_tagged_in,
	input wire logic rx_fcs_error_in,
	input wire logic rx_align_error_in,
	input wire logic rx_symbol_error_in,
	input wire logic rx_collision_in,
	input wire logic rx_pause_frame_in,
	input wire logic rx_unknown_control_opcode_in,
	input wire logic rx_length_mismatch_in,
	input wire logic rx_length_illegal_in,
	input wire logic rx_type_field_in,
	input wire logic rx_gap_shrink_in,
	// ingress fifo events
	input wire logic ingress_overflow_drop_in,
	input wire logic [eps_pkg::PORT_W-1:0] ingress_port_in,
	// transmit mac frame events
	input wire logic tx_frame_done_in,
	input wire logic [eps_pkg::PORT_W-1:0] tx_port_in,
	input wire logic [eps_pkg::LEN_W-1:0] tx_length_in,
	input wire logic [1:0] tx_dest_class_in,
	input wire logic tx_vlan_tagged_in,
	input wire logic tx_ok_in,
	input wire logic tx_pause_frame_in,
	input wire logic [eps_pkg::COLL_W-1:0] tx_collisions_in,
	input wire logic tx_deferred_in,
	input wire logic tx_excess_deferral_in,
	input wire logic tx_late_collision_in,
	input wire logic tx_excess_collision_in,
	input wire logic tx_carrier_sense_error_in,
	// egress fifo and transmit fifo events
	input wire logic [eps_pkg::PORT_W-1:0] egress_port_in,
	input wire logic egress_overflow_drop_in,
	input wire logic egress_aging_drop_in,
	input wire logic tx_underrun_drop_in
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [eps_pkg::CNT_W-1:0] cnt [eps_pkg::NUM_PORTS][eps_pkg::NUM_CNT];
	logic [eps_pkg::LEN_W-1:0] max_len;
	logic [eps_pkg::NUM_CNT-1:0] hit_rx;
	logic [eps_pkg::NUM_CNT-1:0] hit_tx;
	logic [eps_pkg::NUM_CNT-1:0] hit_ing;
	logic [eps_pkg::NUM_CNT-1:0] hit_egr;
	logic [eps_pkg::NUM_CNT-1:0] inc_on;
	logic [eps_pkg::CNT_W-1:0] inc_amt [eps_pkg::NUM_CNT];
	logic [eps_pkg::PORT_W-1:0] inc_port [eps_pkg::NUM_CNT];
	logic [eps_pkg::CMP_W-1:0] rx_len;
	logic [eps_pkg::CMP_W-1:0] rx_lim;
	logic [eps_pkg::CMP_W-1:0] tx_len;
	logic [eps_pkg::CMP_W-1:0] tx_lim;
	logic rx_short;
	logic rx_long;
	logic rx_good;
	logic tx_long;
	logic [6:0] rx_bins;
	logic [6:0] tx_bins;
	logic [eps_pkg::IDX_W-1:0] backoff_idx;
	logic [7:0] page;
	logic cnt_sel;
	logic max_sel;
	logic [eps_pkg::PORT_W-1:0] sel_port;
	logic [eps_pkg::IDX_W-1:0] sel_idx;
	logic bus_commit;
	logic cnt_wr;

	// ****************************************************************
	// length binning, shared by both directions
	// ****************************************************************
	// bit 6 is the above-standard bin; frames under 64 bytes, or above both the
	// limit and 1518 bytes, fall in no bin; receive counts them in its short/long counters, transmit in none
	function automatic logic [6:0] eps_size_bins(input logic [eps_pkg::CMP_W-1:0] len,
		input logic [eps_pkg::CMP_W-1:0] lim);
		logic [6:0] b;
		b = 7'h00;
		b[0] = (len == eps_pkg::LEN_MIN);
		b[1] = (len > eps_pkg::LEN_MIN) && (len <= eps_pkg::LEN_B127);
		b[2] = (len > eps_pkg::LEN_B127) && (len <= eps_pkg::LEN_B255);
		b[3] = (len > eps_pkg::LEN_B255) && (len <= eps_pkg::LEN_B511);
		b[4] = (len > eps_pkg::LEN_B511) && (len <= eps_pkg::LEN_B1023);
		b[5] = (len > eps_pkg::LEN_B1023) && (len <= eps_pkg::LEN_STD_MAX);
		b[6] = (len > eps_pkg::LEN_STD_MAX) && (len <= lim);
		return b;
	endfunction : eps_size_bins

	// ****************************************************************
	// receive classification
	// ****************************************************************
	assign rx_len = {1'b0, rx_length_in};
	assign rx_lim = {1'b0, max_len} + (rx_vlan_tagged_in ? eps_pkg::VLAN_EXTRA : '0);
	assign rx_short = rx_len < eps_pkg::LEN_MIN;
	assign rx_long = rx_len > rx_lim;
	assign rx_good = !rx_short && !rx_long && !rx_fcs_error_in && !rx_align_error_in &&
		!rx_symbol_error_in;
	assign rx_bins = eps_size_bins(rx_len, rx_lim);

	always_comb begin
		hit_rx = '0;
		if (rx_frame_done_in) begin
			hit_rx[eps_pkg::IX_RX_ALL_BYTES] = 1'b1;
			hit_rx[eps_pkg::IX_RX_SYMBOL_ERRORS] = rx_symbol_error_in && !rx_collision_in;
			hit_rx[eps_pkg::IX_RX_PAUSE_FRAMES] = rx_pause_frame_in;
			hit_rx[eps_pkg::IX_RX_UNKNOWN_CONTROL_OPCODE] = rx_unknown_control_opcode_in;
			hit_rx[eps_pkg::IX_RX_GOOD_BYTES] = rx_good;
			hit_rx[eps_pkg::IX_RX_BAD_BYTES] = !rx_good;
			if (rx_good) begin
				case (rx_dest_class_in)
					eps_pkg::EPS_DEST_UNICAST: hit_rx[eps_pkg::IX_RX_GOOD_UNICAST] = 1'b1;
					eps_pkg::EPS_DEST_BROADCAST: hit_rx[eps_pkg::IX_RX_GOOD_BROADCAST] = 1'b1;
					default: hit_rx[eps_pkg::IX_RX_GOOD_MULTICAST] = 1'b1;
				endcase
			end
			// a crc fault on a short or long frame is counted there, not here
			hit_rx[eps_pkg::IX_RX_FCS_ONLY] = rx_fcs_error_in && !rx_align_error_in &&
				!rx_short && !rx_long;
			hit_rx[eps_pkg::IX_RX_ALIGN_ERRORS] = rx_align_error_in;
			hit_rx[eps_pkg::IX_RX_SHORT_GOOD_FCS] = rx_short && !rx_fcs_error_in;
			hit_rx[eps_pkg::IX_RX_SHORT_BAD_FCS] = rx_short && rx_fcs_error_in;
			hit_rx[eps_pkg::IX_RX_LONG_GOOD_FCS] = rx_long && !rx_fcs_error_in;
			hit_rx[eps_pkg::IX_RX_LONG_BAD_FCS] = rx_long && rx_fcs_error_in;
			hit_rx[eps_pkg::IX_RX_LENGTH_MISMATCH] = rx_length_mismatch_in && !rx_type_field_in;
			hit_rx[eps_pkg::IX_RX_LENGTH_ILLEGAL] = rx_length_illegal_in && !rx_type_field_in;
			for (int k = 0; k < 7; k++) begin
				hit_rx[eps_pkg::IX_RX_BIN_BASE + 6'(k)] = rx_bins[k];
			end
		end
		hit_rx[eps_pkg::IX_RX_GAP_SHRINK_EVENTS] = rx_gap_shrink_in;
	end

	always_comb begin
		hit_ing = '0;
		hit_ing[eps_pkg::IX_INGRESS_OVERFLOW_DROP_COUNT] = ingress_overflow_drop_in;
	end

	// ****************************************************************
	// transmit classification
	// ****************************************************************
	assign tx_len = {1'b0, tx_length_in};
	assign tx_lim = {1'b0, max_len} + (tx_vlan_tagged_in ? eps_pkg::VLAN_EXTRA : '0);
	assign tx_long = tx_len > tx_lim;
	assign tx_bins = eps_size_bins(tx_len, tx_lim);
	assign backoff_idx = eps_pkg::IX_TX_OK_AFTER_N_BACKOFFS + {2'b00, tx_collisions_in} -
		{2'b00, eps_pkg::BACKOFF_MIN};

	always_comb begin
		hit_tx = '0;
		if (tx_frame_done_in) begin
			hit_tx[eps_pkg::IX_TX_ALL_BYTES] = 1'b1;
			hit_tx[eps_pkg::IX_TX_GOOD_BYTES] = tx_ok_in;
			hit_tx[eps_pkg::IX_TX_PAUSE_FRAMES] = tx_pause_frame_in;
			if (tx_ok_in) begin
				case (tx_dest_class_in)
					eps_pkg::EPS_DEST_UNICAST: hit_tx[eps_pkg::IX_TX_UNICAST] = 1'b1;
					eps_pkg::EPS_DEST_BROADCAST: hit_tx[eps_pkg::IX_TX_BROADCAST] = 1'b1;
					default: hit_tx[eps_pkg::IX_TX_MULTICAST] = 1'b1;
				endcase
				hit_tx[eps_pkg::IX_TX_OK_AFTER_ONE_COLLISION] = tx_collisions_in == 4'h1;
				if (tx_collisions_in >= eps_pkg::BACKOFF_MIN) begin
					hit_tx[eps_pkg::IX_TX_OK_AFTER_MANY_COLLISIONS] = 1'b1;
					hit_tx[backoff_idx] = 1'b1;
				end
			end
			hit_tx[eps_pkg::IX_TX_LATE_COLLISION_EVENTS] = tx_late_collision_in;
			hit_tx[eps_pkg::IX_TX_EXCESS_COLLISION_LOSSES] = tx_excess_collision_in;
			hit_tx[eps_pkg::IX_TX_FIRST_ATTEMPT_DEFERRED] = tx_deferred_in;
			hit_tx[eps_pkg::IX_TX_EXCESS_DEFERRAL_FRAMES] = tx_excess_deferral_in;
			hit_tx[eps_pkg::IX_TX_CARRIER_SENSE_ERRORS] = tx_carrier_sense_error_in;
			for (int k = 0; k < 7; k++) begin
				hit_tx[eps_pkg::IX_TX_BIN_BASE + 6'(k)] = tx_bins[k];
			end
		end
	end

	always_comb begin
		hit_egr = '0;
		hit_egr[eps_pkg::IX_EGRESS_OVERFLOW_DROP_COUNT] = egress_overflow_drop_in;
		hit_egr[eps_pkg::IX_EGRESS_AGING_DROP_COUNT] = egress_aging_drop_in;
		hit_egr[eps_pkg::IX_TX_UNDERRUN_DROPS] = tx_underrun_drop_in;
	end

	// ****************************************************************
	// routing of increments to a port and an amount
	// ****************************************************************
	// the four hit groups touch disjoint counters, so a plain priority is safe
	always_comb begin
		inc_on = hit_rx | hit_tx | hit_ing | hit_egr;
		for (int c = 0; c < eps_pkg::NUM_CNT; c++) begin
			if (hit_ing[c]) begin
				inc_port[c] = ingress_port_in;
			end else if (hit_tx[c]) begin
				inc_port[c] = tx_port_in;
			end else if (hit_egr[c]) begin
				inc_port[c] = egress_port_in;
			end else begin
				inc_port[c] = rx_port_in;
			end
			if (6'(c) == eps_pkg::IX_RX_ALL_BYTES || 6'(c) == eps_pkg::IX_RX_GOOD_BYTES ||
				6'(c) == eps_pkg::IX_RX_BAD_BYTES) begin
				inc_amt[c] = {18'h00000, rx_length_in};
			end else if (6'(c) == eps_pkg::IX_TX_ALL_BYTES || 6'(c) == eps_pkg::IX_TX_GOOD_BYTES) begin
				inc_amt[c] = {18'h00000, tx_length_in};
			end else begin
				inc_amt[c] = 32'h00000001;
			end
		end
	end

	// ****************************************************************
	// counter storage, one word per port and counter
	// ****************************************************************
	for (genvar p = 0; p < eps_pkg::NUM_PORTS; p++) begin : g_port
		for (genvar c = 0; c < eps_pkg::NUM_CNT; c++) begin : g_cnt
			logic [eps_pkg::CNT_W-1:0] add;
			assign add = (inc_on[c] && inc_port[c] == (eps_pkg::PORT_W)'(p)) ? inc_amt[c] : '0;
			// a software write adds the same-cycle event so that no count is lost
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cnt[p][c] <= '0;
				end else if (cnt_wr && sel_port == (eps_pkg::PORT_W)'(p) &&
					sel_idx == (eps_pkg::IDX_W)'(c)) begin
					cnt[p][c] <= avs_writedata_in + add;
				end else begin
					cnt[p][c] <= cnt[p][c] + add;
				end
			end
		end
	end

	// ****************************************************************
	// avalon-mm slave
	// ****************************************************************
	assign page = avs_address_in[15:8] - eps_pkg::CNT_PAGE;
	assign cnt_sel = page < 8'(eps_pkg::NUM_PORTS);
	assign sel_port = page[eps_pkg::PORT_W-1:0];
	assign sel_idx = avs_address_in[7:2];
	assign max_sel = avs_address_in[15:2] == eps_pkg::ADDR_MAX_LEN[15:2];
	// a write takes effect at the edge where the master sees waitrequest low
	assign bus_commit = avs_write_in && !avs_waitrequest_out;
	// counters only take full-word writes; partial lanes would tear a live count
	assign cnt_wr = bus_commit && cnt_sel && avs_byteenable_in == eps_pkg::BE_FULL;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_waitrequest_out <= 1'b1;
		end else if (!avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b1;
		end else if (avs_read_in || avs_write_in) begin
			avs_waitrequest_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= '0;
		end else if (avs_read_in && avs_waitrequest_out) begin
			if (cnt_sel) begin
				avs_readdata_out <= cnt[sel_port][sel_idx];
			end else if (max_sel) begin
				avs_readdata_out <= {18'h00000, max_len};
			end else begin
				avs_readdata_out <= '0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			max_len <= eps_pkg::MAX_LEN_RST;
		end else if (bus_commit && max_sel) begin
			if (avs_byteenable_in[0]) begin
				max_len[7:0] <= avs_writedata_in[7:0];
			end
			if (avs_byteenable_in[1]) begin
				max_len[13:8] <= avs_writedata_in[13:8];
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb_main @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	logic wr_port0;
	assign wr_port0 = cnt_wr && sel_port == '0;

	sequence s_bus_req;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence

	sequence s_bus_ack;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence

	chk_bus_answer: assert property (s_bus_req |=> s_bus_ack)
		else $error("waitrequest did not drop for exactly one cycle");

	chk_rx_total_bytes: assert property (
		rx_frame_done_in && rx_port_in == '0 && !wr_port0 |=>
		cnt[0][eps_pkg::IX_RX_ALL_BYTES] ==
		$past(cnt[0][eps_pkg::IX_RX_ALL_BYTES]) + {18'h00000, $past(rx_length_in)})
		else $error("receive byte total did not add the frame length");

	chk_ingress_drop_one: assert property (
		ingress_overflow_drop_in && ingress_port_in == '0 && !wr_port0 |=>
		cnt[0][eps_pkg::IX_INGRESS_OVERFLOW_DROP_COUNT] ==
		$past(cnt[0][eps_pkg::IX_INGRESS_OVERFLOW_DROP_COUNT]) + 32'h00000001)
		else $error("ingress overflow drop not counted by one");

	chk_symbol_no_coll: assert property (
		rx_collision_in |-> !hit_rx[eps_pkg::IX_RX_SYMBOL_ERRORS])
		else $error("symbol error counted during collision");

	chk_rx_cast_onehot: assert property (
		rx_frame_done_in |-> (rx_good ?
		$onehot(hit_rx[eps_pkg::IX_RX_GOOD_BROADCAST:eps_pkg::IX_RX_GOOD_UNICAST]) :
		hit_rx[eps_pkg::IX_RX_GOOD_BROADCAST:eps_pkg::IX_RX_GOOD_UNICAST] == 3'h0))
		else $error("good frame address class not counted exactly once");

	chk_short_split: assert property (
		rx_frame_done_in && rx_short |->
		hit_rx[eps_pkg::IX_RX_SHORT_BAD_FCS] == rx_fcs_error_in &&
		hit_rx[eps_pkg::IX_RX_SHORT_GOOD_FCS] == !rx_fcs_error_in &&
		!hit_rx[eps_pkg::IX_RX_FCS_ONLY])
		else $error("short frame split on crc is wrong");

	chk_long_split: assert property (
		rx_frame_done_in && rx_long |->
		hit_rx[eps_pkg::IX_RX_LONG_BAD_FCS] == rx_fcs_error_in &&
		hit_rx[eps_pkg::IX_RX_LONG_GOOD_FCS] == !rx_fcs_error_in)
		else $error("long frame split on crc is wrong");

	chk_type_no_illegal: assert property (
		rx_type_field_in |-> !hit_rx[eps_pkg::IX_RX_LENGTH_ILLEGAL])
		else $error("type-field frame counted as illegal length");

	chk_vlan_limit: assert property (
		rx_frame_done_in && rx_vlan_tagged_in && rx_len > eps_pkg::LEN_STD_MAX &&
		rx_len == {1'b0, max_len} + eps_pkg::VLAN_EXTRA |->
		hit_rx[eps_pkg::IX_RX_BIN_ABOVE_STANDARD] && !rx_long)
		else $error("tagged frame at limit plus four not binned");

	chk_tx_ok_bytes: assert property (
		tx_frame_done_in && !tx_ok_in |->
		hit_tx[eps_pkg::IX_TX_ALL_BYTES] && !hit_tx[eps_pkg::IX_TX_GOOD_BYTES])
		else $error("failed transmit counted as successful bytes");

	chk_backoff_bins: assert property (
		tx_frame_done_in && tx_ok_in && tx_collisions_in >= eps_pkg::BACKOFF_MIN |->
		$onehot(hit_tx[eps_pkg::IX_TX_BACKOFF_LAST:eps_pkg::IX_TX_OK_AFTER_N_BACKOFFS]) &&
		hit_tx[eps_pkg::IX_TX_OK_AFTER_N_BACKOFFS + {2'b00, tx_collisions_in} - 6'h02])
		else $error("backoff bin does not match collision count");

	chk_counter_wrap: assert property (
		cnt[0][eps_pkg::IX_TX_UNDERRUN_DROPS] == 32'hffffffff && tx_underrun_drop_in &&
		egress_port_in == '0 && !wr_port0 |=> cnt[0][eps_pkg::IX_TX_UNDERRUN_DROPS] == '0)
		else $error("counter did not wrap to zero");

endmodule : eps_port_stats

// ===== verif/eps_mac_model.sv
// eps_mac_model: stand-in for the mac, ingress fifo and egress fifo event sources.
// assumes its tasks are called right after a rising clk_in edge.
`timescale 1ns/10ps

module eps_mac_model (
	input wire logic clk_in,
	output logic rx_done_out,
	output logic [1:0] rx_port_out,
	output logic [13:0] rx_len_out,
	output logic [1:0] rx_dest_out,
	output logic [9:0] rx_flag_out,
	output logic tx_done_out,
	output logic [1:0] tx_port_out,
	output logic [13:0] tx_len_out,
	output logic [1:0] tx_dest_out,
	output logic [3:0] tx_coll_out,
	output logic [7:0] tx_flag_out,
	output logic [4:0] misc_out,
	output logic [1:0] misc_port_out
);
	// ****************************************************************
	// event pulses
	// ****************************************************************
	initial begin
		{rx_done_out, rx_port_out, rx_len_out, rx_dest_out, rx_flag_out} = '0;
		{tx_done_out, tx_port_out, tx_len_out, tx_dest_out, tx_coll_out, tx_flag_out} = '0;
		{misc_out, misc_port_out} = '0;
	end

	// flags, rx length, tx collisions and misc port go inverted after the strobe so nothing leans on stale values
	task automatic rx(input logic [1:0] p, input logic [13:0] l, input logic [1:0] d,
			input logic [9:0] f);
		rx_done_out <= 1'b1;
		rx_port_out <= p;
		rx_len_out <= l;
		rx_dest_out <= d;
		rx_flag_out <= f;
		@(posedge clk_in);
		rx_done_out <= 1'b0;
		rx_len_out <= ~l;
		rx_flag_out <= ~f;
		@(posedge clk_in);
	endtask : rx

	task automatic tx(input logic [1:0] p, input logic [13:0] l, input logic [1:0] d,
			input logic [3:0] c, input logic [7:0] f);
		tx_done_out <= 1'b1;
		tx_port_out <= p;
		tx_len_out <= l;
		tx_dest_out <= d;
		tx_coll_out <= c;
		tx_flag_out <= f;
		@(posedge clk_in);
		tx_done_out <= 1'b0;
		tx_coll_out <= ~c;
		tx_flag_out <= ~f;
		@(posedge clk_in);
	endtask : tx

	task automatic misc(input logic [1:0] p, input logic [4:0] m);
		misc_out <= m;
		misc_port_out <= p;
		rx_port_out <= p;
		@(posedge clk_in);
		misc_out <= 5'h00;
		misc_port_out <= ~p;
		@(posedge clk_in);
	endtask : misc
endmodule : eps_mac_model

// ===== verif/eps_port_stats_bench.sv
// eps_port_stats_bench: self-checking bench, counters read back over avalon-mm.
// assumes eps_pkg and eps_port_stats are compiled first.
`timescale 1ns/10ps

module eps_port_stats_bench;
	// ****************************************************************
	// harness
	// ****************************************************************
	logic clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [15:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rdv;
	logic [3:0] avs_byteenable_in, tx_coll_out;
	logic rx_done_out, tx_done_out;
	logic [1:0] rx_port_out, rx_dest_out, tx_port_out, tx_dest_out, misc_port_out;
	logic [13:0] rx_len_out, tx_len_out;
	logic [9:0] rx_flag_out;
	logic [7:0] tx_flag_out;
	logic [4:0] misc_out;
	int n_fail = 0, checked = 0, cyc = 0;

	eps_port_stats dut (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.rx_frame_done_in(rx_done_out), .rx_port_in(rx_port_out), .rx_length_in(rx_len_out),
		.rx_dest_class_in(rx_dest_out), .rx_vlan_tagged_in(rx_flag_out[9]),
		.rx_fcs_error_in(rx_flag_out[8]), .rx_align_error_in(rx_flag_out[7]),
		.rx_symbol_error_in(rx_flag_out[6]), .rx_collision_in(rx_flag_out[5]),
		.rx_pause_frame_in(rx_flag_out[4]), .rx_unknown_control_opcode_in(rx_flag_out[3]),
		.rx_length_mismatch_in(rx_flag_out[2]), .rx_length_illegal_in(rx_flag_out[1]),
		.rx_type_field_in(rx_flag_out[0]), .rx_gap_shrink_in(misc_out[4]),
		.ingress_overflow_drop_in(misc_out[3]), .ingress_port_in(misc_port_out),
		.tx_frame_done_in(tx_done_out), .tx_port_in(tx_port_out), .tx_length_in(tx_len_out),
		.tx_dest_class_in(tx_dest_out), .tx_vlan_tagged_in(tx_flag_out[7]),
		.tx_ok_in(tx_flag_out[6]), .tx_pause_frame_in(tx_flag_out[5]),
		.tx_collisions_in(tx_coll_out), .tx_deferred_in(tx_flag_out[4]),
		.tx_excess_deferral_in(tx_flag_out[3]), .tx_late_collision_in(tx_flag_out[2]),
		.tx_excess_collision_in(tx_flag_out[1]), .tx_carrier_sense_error_in(tx_flag_out[0]),
		.egress_port_in(misc_port_out), .egress_overflow_drop_in(misc_out[2]),
		.egress_aging_drop_in(misc_out[1]), .tx_underrun_drop_in(misc_out[0]));
	eps_mac_model mac (.clk_in, .rx_done_out, .rx_port_out, .rx_len_out, .rx_dest_out,
		.rx_flag_out, .tx_done_out, .tx_port_out, .tx_len_out, .tx_dest_out, .tx_coll_out,
		.tx_flag_out, .misc_out, .misc_port_out);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one avalon transfer, held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd);
		avs_address_in <= a;
		avs_writedata_in <= wd;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		rdv = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		// one idle edge so a following call never re-drives a strobe in this step
		@(posedge clk_in);
	endtask : xfer

	function automatic logic [15:0] ca(input logic [1:0] p, input logic [5:0] ix);
		return {4'h1, 2'b00, p, ix, 2'b00};
	endfunction : ca

	task automatic rc(input logic [1:0] p, input logic [5:0] ix, input logic [31:0] e);
		xfer(1'b0, ca(p, ix), 32'h0);
		chk(rdv, e);
	endtask : rc

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// a hung handshake ends the run here
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		rst_n_in = 1'b0;
		{avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
		avs_byteenable_in = 4'hf;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		xfer(1'b0, eps_pkg::ADDR_MAX_LEN, 32'h0);
		chk(rdv, 32'h0000_05ee);
		mac.rx(2'h1, 14'h0040, 2'h0, 10'h000);
		mac.rx(2'h2, 14'h003c, 2'h0, 10'h100);
		mac.rx(2'h2, 14'h0028, 2'h0, 10'h000);
		mac.rx(2'h3, 14'h05f2, 2'h0, 10'h200);
		mac.rx(2'h3, 14'h0640, 2'h0, 10'h000);
		mac.rx(2'h3, 14'h0640, 2'h0, 10'h100);
		mac.rx(2'h3, 14'h0064, 2'h2, 10'h040);
		mac.rx(2'h3, 14'h0064, 2'h0, 10'h060);
		mac.rx(2'h3, 14'h0040, 2'h1, 10'h010);
		mac.tx(2'h0, 14'h0080, 2'h2, 4'h3, 8'h40);
		mac.tx(2'h0, 14'h0040, 2'h0, 4'h1, 8'h40);
		mac.misc(2'h0, 5'h1f);
		rc(2'h1, eps_pkg::IX_RX_ALL_BYTES, 32'h40);
		rc(2'h1, eps_pkg::IX_RX_GOOD_UNICAST, 32'h1);
		rc(2'h1, eps_pkg::IX_RX_BIN_BASE, 32'h1);
		rc(2'h2, eps_pkg::IX_RX_SHORT_BAD_FCS, 32'h1);
		rc(2'h2, eps_pkg::IX_RX_SHORT_GOOD_FCS, 32'h1);
		rc(2'h2, eps_pkg::IX_RX_BAD_BYTES, 32'h64);
		rc(2'h3, eps_pkg::IX_RX_BIN_ABOVE_STANDARD, 32'h1);
		rc(2'h3, eps_pkg::IX_RX_LONG_GOOD_FCS, 32'h1);
		rc(2'h3, eps_pkg::IX_RX_LONG_BAD_FCS, 32'h1);
		rc(2'h3, eps_pkg::IX_RX_SYMBOL_ERRORS, 32'h1);
		rc(2'h3, eps_pkg::IX_RX_PAUSE_FRAMES, 32'h1);
		rc(2'h3, eps_pkg::IX_RX_GOOD_BYTES, 32'h632);
		rc(2'h3, eps_pkg::IX_RX_GOOD_BROADCAST, 32'h0);
		rc(2'h3, eps_pkg::IX_RX_GOOD_MULTICAST, 32'h1);
		rc(2'h0, eps_pkg::IX_TX_OK_AFTER_N_BACKOFFS + 6'h01, 32'h1);
		rc(2'h0, eps_pkg::IX_TX_OK_AFTER_MANY_COLLISIONS, 32'h1);
		rc(2'h0, eps_pkg::IX_TX_OK_AFTER_ONE_COLLISION, 32'h1);
		rc(2'h0, eps_pkg::IX_TX_BIN_BASE + 6'h02, 32'h1);
		rc(2'h0, eps_pkg::IX_TX_GOOD_BYTES, 32'hc0);
		rc(2'h0, eps_pkg::IX_TX_BROADCAST, 32'h1);
		rc(2'h0, eps_pkg::IX_INGRESS_OVERFLOW_DROP_COUNT, 32'h1);
		rc(2'h0, eps_pkg::IX_EGRESS_OVERFLOW_DROP_COUNT, 32'h1);
		rc(2'h0, eps_pkg::IX_EGRESS_AGING_DROP_COUNT, 32'h1);
		rc(2'h0, eps_pkg::IX_TX_UNDERRUN_DROPS, 32'h1);
		rc(2'h0, eps_pkg::IX_RX_GAP_SHRINK_EVENTS, 32'h1);
		xfer(1'b1, ca(2'h0, eps_pkg::IX_RX_ALL_BYTES), 32'hffff_fff0);
		mac.rx(2'h0, 14'h0040, 2'h0, 10'h000);
		rc(2'h0, eps_pkg::IX_RX_ALL_BYTES, 32'h30);
		rc(2'h2, eps_pkg::IX_RX_GOOD_UNICAST, 32'h0);
		xfer(1'b1, ca(2'h0, eps_pkg::IX_TX_UNDERRUN_DROPS), 32'hffff_ffff);
		mac.misc(2'h0, 5'h01);
		rc(2'h0, eps_pkg::IX_TX_UNDERRUN_DROPS, 32'h0);
		mac.rx(2'h1, 14'h0064, 2'h0, 10'h10e);
		mac.rx(2'h1, 14'h0064, 2'h0, 10'h183);
		rc(2'h1, eps_pkg::IX_RX_FCS_ONLY, 32'h1);
		rc(2'h1, eps_pkg::IX_RX_ALIGN_ERRORS, 32'h1);
		rc(2'h1, eps_pkg::IX_RX_UNKNOWN_CONTROL_OPCODE, 32'h1);
		rc(2'h1, eps_pkg::IX_RX_LENGTH_MISMATCH, 32'h1);
		rc(2'h1, eps_pkg::IX_RX_LENGTH_ILLEGAL, 32'h1);
		mac.tx(2'h1, 14'h05f0, 2'h0, 4'h0, 8'hbf);
		rc(2'h1, eps_pkg::IX_TX_ALL_BYTES, 32'h5f0);
		rc(2'h1, eps_pkg::IX_TX_GOOD_BYTES, 32'h0);
		rc(2'h1, eps_pkg::IX_TX_BIN_ABOVE_STANDARD, 32'h1);
		rc(2'h1, eps_pkg::IX_TX_PAUSE_FRAMES, 32'h1);
		rc(2'h1, eps_pkg::IX_TX_LATE_COLLISION_EVENTS, 32'h1);
		rc(2'h1, eps_pkg::IX_TX_EXCESS_COLLISION_LOSSES, 32'h1);
		rc(2'h1, eps_pkg::IX_TX_FIRST_ATTEMPT_DEFERRED, 32'h1);
		rc(2'h1, eps_pkg::IX_TX_EXCESS_DEFERRAL_FRAMES, 32'h1);
		rc(2'h1, eps_pkg::IX_TX_CARRIER_SENSE_ERRORS, 32'h1);
		avs_byteenable_in <= 4'h3;
		xfer(1'b1, ca(2'h0, eps_pkg::IX_RX_ALL_BYTES), 32'h0);
		xfer(1'b1, eps_pkg::ADDR_MAX_LEN, 32'h0000_0600);
		avs_byteenable_in <= 4'hf;
		rc(2'h0, eps_pkg::IX_RX_ALL_BYTES, 32'h30);
		xfer(1'b0, eps_pkg::ADDR_MAX_LEN, 32'h0);
		chk(rdv, 32'h0000_0600);
		mac.rx(2'h2, 14'h0600, 2'h0, 10'h000);
		rc(2'h2, eps_pkg::IX_RX_BIN_ABOVE_STANDARD, 32'h1);
		rc(2'h2, eps_pkg::IX_RX_LONG_GOOD_FCS, 32'h0);
		xfer(1'b0, 16'h0ffc, 32'h0);
		chk(rdv, 32'h0);
		close_out();
	end
endmodule : eps_port_stats_bench
